// File: common/mmsc_defs.vh
// constants of the module management slave controller
// Function
// - answer bus transactions while select is low
// - ignore bus and release data when deselected
// - long reset pulse restores all user settings; user page 02 keeps its content
// - completion interval counts from reset rising edge
// - completion shown as attention with not-ready clear
// - power-up posts completion attention without reset pulse
// - low power select high enters reduced power
// - presence output low while module inserted
// - attention driven low on fault or status
// - one lower page plus shared upper pages
// - flags and monitors live in lower page
// - upper content reached through page select byte
// - page select picks page 00, 02, 03
// - respond at seven-bit address 1010000
`ifndef MMSC_DEFS_VH
`define MMSC_DEFS_VH

// ---------------------------------------------------------------
// bus address and page selection
// ---------------------------------------------------------------
`define MMSC_DEV_ADDR 7'h50
`define MMSC_PAGE_SEL_OFS 8'h7f
`define MMSC_PAGE_SEL_RST 8'h00
`define MMSC_PAGE_BASE_ID 8'h00
`define MMSC_PAGE_USER 8'h02
`define MMSC_PAGE_THRESH 8'h03

// ---------------------------------------------------------------
// lower page layout
// ---------------------------------------------------------------
`define MMSC_STATUS_OFS 8'h02
`define MMSC_NOT_READY_BIT 0
`define MMSC_FLAG_OFS 8'h03
`define MMSC_FLAG_DONE_BIT 0
`define MMSC_FLAG_FAULT_BIT 1
`define MMSC_MASK_OFS 8'h64
`define MMSC_LOW_RO_LAST 7'h55
`define MMSC_P3_RW_FIRST 7'h62

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MMSC_CLK_NS 10
`define MMSC_T_RESET_MIN_NS 10000
`define MMSC_T_INIT_US 2000
`define MMSC_RESET_MIN_CYC \
   ((`MMSC_T_RESET_MIN_NS + `MMSC_CLK_NS - 1) / `MMSC_CLK_NS)
`define MMSC_INIT_CYC ((`MMSC_T_INIT_US * 1000) / `MMSC_CLK_NS)

`endif

// File: verilog/mmsc_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module mmsc_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
   input wire clock,
   input wire rst_n,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] s1_q;
   reg [WIDTH-1:0] s2_q;
   reg [WIDTH-1:0] s3_q;
   integer i;

   // first stage feeds only the second; output moves when 2 and 3 agree
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         dout <= INIT;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2_q[i] == s3_q[i]) begin
               dout[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

// File: verilog/mmsc_top.v
// management slave: 2-wire memory, module reset and attention pins
`timescale 1ns/1ns
`include "mmsc_defs.vh"
module mmsc_top #(
   parameter [31:0] INIT_CYCLES = `MMSC_INIT_CYC,
   parameter [15:0] RESET_MIN_CYCLES = `MMSC_RESET_MIN_CYC
) (
   input wire clock,
   input wire nrst,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out_q,
   output reg sda_oe_n_q,
   input wire module_select_n,
   input wire module_reset_n,
   input wire low_power_select,
   input wire fault_event,
   output reg presence_n_q,
   output reg attention_out_q,
   output reg attention_oe_n_q,
   output reg low_power_active_q,
   output reg data_not_ready_q
);
   // ------------------------------------------------------------
   // states and declarations
   // ------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_ADDR = 3'd1;
   localparam [2:0] ST_ACK_A = 3'd2;
   localparam [2:0] ST_WR = 3'd3;
   localparam [2:0] ST_ACK_W = 3'd4;
   localparam [2:0] ST_RD = 3'd5;
   localparam [2:0] ST_RACK = 3'd6;

   reg rst_s1_q;
   reg rst_n;
   wire [4:0] pins_s;
   wire scl_s;
   wire sda_s;
   wire sel_n_s;
   wire mrst_n_s;
   wire lps_s;
   reg scl_prev_q;
   reg sda_prev_q;
   reg mrst_prev_q;
   reg [2:0] st_q;
   reg [3:0] bitcnt_q;
   reg [7:0] shift_q;
   reg [7:0] tx_q;
   reg [7:0] addr_q;
   reg [7:0] page_sel_q;
   reg first_q;
   reg mack_q;
   reg host_we_q;
   reg [8:0] host_idx_q;
   reg [7:0] host_data_q;
   reg [1:0] rd_clr_q;
   reg [15:0] low_cnt_q;
   reg [31:0] init_cnt_q;
   reg wipe_busy_q;
   reg pwr_wipe_q;
   reg [8:0] wipe_ptr_q;
   reg [1:0] flag_q;
   reg [1:0] flag_d;
   reg [7:0] rd_data;
   reg [7:0] mem [0:511];
   wire scl_rise;
   wire scl_fall;
   wire start_c;
   wire stop_c;
   wire armed;
   wire init_start;
   wire init_done;
   wire [9:0] rd_map;
   wire [9:0] wr_map;

   // ------------------------------------------------------------
   // address mapping helpers
   // ------------------------------------------------------------
   // returns {valid, index}; bank 0 lower, banks 1..3 pages 00/02/03
   function [9:0] map_idx;
      input [7:0] a;
      input [7:0] pg;
      begin
         if (!a[7]) begin
            map_idx = {1'b1, 2'b00, a[6:0]};
         end else if (pg == `MMSC_PAGE_BASE_ID) begin
            map_idx = {1'b1, 2'b01, a[6:0]};
         end else if (pg == `MMSC_PAGE_USER) begin
            map_idx = {1'b1, 2'b10, a[6:0]};
         end else if (pg == `MMSC_PAGE_THRESH) begin
            map_idx = {1'b1, 2'b11, a[6:0]};
         end else begin
            map_idx = {1'b0, 2'b00, a[6:0]};
         end
      end
   endfunction

   // user settings: lower control area and page 03 control area
   function is_setting;
      input [8:0] idx;
      begin
         is_setting = ((idx[8:7] == 2'b00) &&
                       (idx[6:0] > `MMSC_LOW_RO_LAST)) ||
                      ((idx[8:7] == 2'b11) &&
                       (idx[6:0] >= `MMSC_P3_RW_FIRST));
      end
   endfunction

   // host may write settings and the user page
   function is_writable;
      input [8:0] idx;
      begin
         is_writable = is_setting(idx) || (idx[8:7] == 2'b10);
      end
   endfunction

   // ------------------------------------------------------------
   // reset release and pin synchronisers
   // ------------------------------------------------------------
   // nrst is released through two flops
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   mmsc_sync #(
      .WIDTH(5),
      .INIT(5'h0f)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .din({low_power_select, module_reset_n, module_select_n,
            sda_in, scl_in}),
      .dout(pins_s)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign sel_n_s = pins_s[2];
   assign mrst_n_s = pins_s[3];
   assign lps_s = pins_s[4];

   // bus edges and start/stop conditions from filtered levels
   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_c = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // ------------------------------------------------------------
   // module reset and completion sequencing
   // ------------------------------------------------------------
   assign armed = (low_cnt_q >= RESET_MIN_CYCLES);
   assign init_start = mrst_n_s & ~mrst_prev_q & armed;
   assign init_done = data_not_ready_q & (init_cnt_q == 32'h0) &
                      ~wipe_busy_q;

   // power-up behaves as a completed reset pulse, so the first
   // completion attention needs no pin activity
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mrst_prev_q <= 1'b1;
         low_cnt_q <= 16'h0;
         init_cnt_q <= INIT_CYCLES;
         data_not_ready_q <= 1'b1;
         wipe_busy_q <= 1'b1;
         pwr_wipe_q <= 1'b1;
         wipe_ptr_q <= 9'h0;
      end else begin
         mrst_prev_q <= mrst_n_s;
         if (!mrst_n_s) begin
            if (!armed) begin
               low_cnt_q <= low_cnt_q + 16'h1;
            end else begin
               data_not_ready_q <= 1'b1;
               init_cnt_q <= INIT_CYCLES;
            end
         end else begin
            low_cnt_q <= 16'h0;
            if (init_cnt_q != 32'h0) begin
               init_cnt_q <= init_cnt_q - 32'h1;
            end
         end
         if (init_start) begin
            wipe_busy_q <= 1'b1;
            pwr_wipe_q <= 1'b0;
            wipe_ptr_q <= 9'h0;
         end else if (wipe_busy_q) begin
            wipe_ptr_q <= wipe_ptr_q + 9'h1;
            if (wipe_ptr_q == 9'h1ff) begin
               wipe_busy_q <= 1'b0;
            end
         end
         if (init_done && mrst_n_s) begin
            data_not_ready_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // flags, attention and simple pins
   // ------------------------------------------------------------
   // clear-on-read drops only the bits the host was shown, so a set
   // landing just before or with the clear is never lost
   always @* begin
      flag_d = flag_q & ~rd_clr_q;
      if (init_start) begin
         flag_d = 2'b00;
      end
      if (init_done && mrst_n_s) begin
         flag_d[`MMSC_FLAG_DONE_BIT] = 1'b1;
      end
      if (fault_event) begin
         flag_d[`MMSC_FLAG_FAULT_BIT] = 1'b1;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 2'b00;
         attention_oe_n_q <= 1'b1;
         attention_out_q <= 1'b0;
         presence_n_q <= 1'b0;
         low_power_active_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         // open collector: pull low while an unmasked flag stands
         attention_oe_n_q <= ~|(flag_q &
                                ~mem[`MMSC_MASK_OFS][1:0]);
         attention_out_q <= 1'b0;
         presence_n_q <= 1'b0;
         low_power_active_q <= lps_s;
      end
   end

   // ------------------------------------------------------------
   // memory array: wipe has priority over host writes
   // ------------------------------------------------------------
   // host writes land only in cycles where the wipe clears nothing, so one can slip in behind a reset wipe
   always @(posedge clock) begin
      if (wipe_busy_q && (pwr_wipe_q || is_setting(wipe_ptr_q))) begin
         mem[wipe_ptr_q] <= 8'h00;
      end else if (host_we_q) begin
         mem[host_idx_q] <= host_data_q;
      end
   end

   assign rd_map = map_idx(addr_q, page_sel_q);
   assign wr_map = map_idx(addr_q, page_sel_q);

   // read byte at the current pointer, live bits spliced in
   always @* begin
      rd_data = 8'h00;
      if (addr_q == `MMSC_STATUS_OFS) begin
         rd_data = mem[rd_map[8:0]];
         rd_data[`MMSC_NOT_READY_BIT] = data_not_ready_q;
      end else if (addr_q == `MMSC_FLAG_OFS) begin
         rd_data = {6'h00, flag_q};
      end else if (addr_q == `MMSC_PAGE_SEL_OFS) begin
         rd_data = page_sel_q;
      end else if (rd_map[9]) begin
         rd_data = mem[rd_map[8:0]];
      end
   end

   // ------------------------------------------------------------
   // 2-wire slave state machine
   // ------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         st_q <= ST_IDLE;
         bitcnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         addr_q <= 8'h00;
         page_sel_q <= `MMSC_PAGE_SEL_RST;
         first_q <= 1'b0;
         mack_q <= 1'b0;
         host_we_q <= 1'b0;
         host_idx_q <= 9'h0;
         host_data_q <= 8'h00;
         rd_clr_q <= 2'b00;
         sda_out_q <= 1'b0;
         sda_oe_n_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         host_we_q <= 1'b0;
         rd_clr_q <= 2'b00;
         sda_out_q <= 1'b0;
         if (init_start) begin
            page_sel_q <= `MMSC_PAGE_SEL_RST;
         end
         if (sel_n_s) begin
            st_q <= ST_IDLE;
            sda_oe_n_q <= 1'b1;
         end else if (start_c) begin
            st_q <= ST_ADDR;
            bitcnt_q <= 4'h0;
            sda_oe_n_q <= 1'b1;
         end else if (stop_c) begin
            st_q <= ST_IDLE;
            sda_oe_n_q <= 1'b1;
         end else begin
            case (st_q)
               ST_ADDR: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     bitcnt_q <= bitcnt_q + 4'h1;
                  end else if (scl_fall && bitcnt_q == 4'h8) begin
                     if (shift_q[7:1] == `MMSC_DEV_ADDR) begin
                        sda_oe_n_q <= 1'b0;
                        st_q <= ST_ACK_A;
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end
               end
               ST_ACK_A: begin
                  if (scl_fall) begin
                     bitcnt_q <= 4'h0;
                     if (shift_q[0]) begin
                        tx_q <= rd_data;
                        sda_oe_n_q <= rd_data[7];
                        addr_q <= addr_q + 8'h01;
                        rd_clr_q <= (addr_q == `MMSC_FLAG_OFS) ?
                                    flag_q : 2'b00;
                        st_q <= ST_RD;
                     end else begin
                        sda_oe_n_q <= 1'b1;
                        first_q <= 1'b1;
                        st_q <= ST_WR;
                     end
                  end
               end
               ST_WR: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     bitcnt_q <= bitcnt_q + 4'h1;
                  end else if (scl_fall && bitcnt_q == 4'h8) begin
                     sda_oe_n_q <= 1'b0;
                     st_q <= ST_ACK_W;
                     first_q <= 1'b0;
                     if (first_q) begin
                        addr_q <= shift_q;
                     end else begin
                        addr_q <= addr_q + 8'h01;
                        if (addr_q == `MMSC_PAGE_SEL_OFS) begin
                           page_sel_q <= shift_q;
                        end else begin
                           host_we_q <= wr_map[9] &
                                        is_writable(wr_map[8:0]);
                           host_idx_q <= wr_map[8:0];
                           host_data_q <= shift_q;
                        end
                     end
                  end
               end
               ST_ACK_W: begin
                  if (scl_fall) begin
                     sda_oe_n_q <= 1'b1;
                     bitcnt_q <= 4'h0;
                     st_q <= ST_WR;
                  end
               end
               ST_RD: begin
                  if (scl_rise) begin
                     bitcnt_q <= bitcnt_q + 4'h1;
                  end else if (scl_fall) begin
                     if (bitcnt_q == 4'h8) begin
                        sda_oe_n_q <= 1'b1;
                        st_q <= ST_RACK;
                     end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_n_q <= tx_q[6];
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     mack_q <= ~sda_s;
                  end else if (scl_fall) begin
                     bitcnt_q <= 4'h0;
                     if (mack_q) begin
                        tx_q <= rd_data;
                        sda_oe_n_q <= rd_data[7];
                        addr_q <= addr_q + 8'h01;
                        rd_clr_q <= (addr_q == `MMSC_FLAG_OFS) ?
                                    flag_q : 2'b00;
                        st_q <= ST_RD;
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  st_q <= ST_IDLE;
                  sda_oe_n_q <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule

// File: tb/mmsc_top_asserts.sv
// port assertions for the management slave controller
`timescale 1ns/1ns
module mmsc_checker #(
   parameter [31:0] INIT_CYCLES = 32'd600,
   parameter [15:0] RESET_MIN_CYCLES = 16'd20
) (
   input wire clock,
   input wire nrst,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out_q,
   input wire sda_oe_n_q,
   input wire module_select_n,
   input wire module_reset_n,
   input wire low_power_select,
   input wire fault_event,
   input wire presence_n_q,
   input wire attention_out_q,
   input wire attention_oe_n_q,
   input wire low_power_active_q,
   input wire data_not_ready_q
);
   reg [31:0] busy_cnt_q;
   reg [15:0] low_cnt_q;
   default clocking dcb @(posedge clock); endclocking
   default disable iff (!nrst);
   // busy count from the output, low count from the raw pin; sync delay makes the latter start and clear four cycles before the design's
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         busy_cnt_q <= 32'h0;
         low_cnt_q <= 16'h0;
      end else begin
         busy_cnt_q <= data_not_ready_q ? busy_cnt_q + 32'h1 : 32'h0;
         low_cnt_q <= module_reset_n ? 16'h0 :
                      low_cnt_q + {15'h0, ~&low_cnt_q};
      end
   end
   sel_deaf_a: assert property (module_select_n [*8] |-> sda_oe_n_q)
      else $error("data line driven while deselected");
   drive_low_a: assert property (!sda_out_q && !attention_out_q)
      else $error("open drain pin driven high");
   presence_a: assert property (!presence_n_q)
      else $error("presence not shown");
   done_attn_a: assert property ($fell(data_not_ready_q) |->
      ##[1:2] !attention_oe_n_q) else $error("no completion attention");
   init_span_a: assert property ($fell(data_not_ready_q) |->
      busy_cnt_q >= INIT_CYCLES) else $error("init interval too short");
   short_pulse_a: assert property ($rose(data_not_ready_q) |->
      low_cnt_q >= RESET_MIN_CYCLES) else $error("short pulse reset");
   long_pulse_a: assert property (
      low_cnt_q > RESET_MIN_CYCLES + 16'h8 |-> data_not_ready_q)
      else $error("long pulse did not reset");
   low_power_a: assert property (low_power_select [*8] |->
      low_power_active_q) else $error("low power not entered");
   full_power_a: assert property (!low_power_select [*8] |->
      !low_power_active_q) else $error("low power not left");
   sda_edge_a: assert property (!$stable(sda_oe_n_q) |-> !scl_in)
      else $error("data changed while clock high");
endmodule
bind mmsc_top mmsc_checker #(.INIT_CYCLES(INIT_CYCLES),
   .RESET_MIN_CYCLES(RESET_MIN_CYCLES)) i_mmsc_checker (
   .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q),
   .module_select_n(module_select_n), .module_reset_n(module_reset_n),
   .low_power_select(low_power_select), .fault_event(fault_event),
   .presence_n_q(presence_n_q), .attention_out_q(attention_out_q),
   .attention_oe_n_q(attention_oe_n_q),
   .low_power_active_q(low_power_active_q),
   .data_not_ready_q(data_not_ready_q));

// File: tb/mmsc_host.sv
// host side 2-wire master model with an open drain data line and a driven clock
`timescale 1ns/1ns
module mmsc_host (
   input wire clock,
   input wire sda_line,
   output reg scl,
   output reg sda_rel
);
   // clock stands high and data released outside frames
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   // half bit of ten clocks, above the eight-clock minimum
   task half;
      begin
         repeat (10) @(posedge clock);
         #1;
      end
   endtask
   // data moves two clocks after the fall so it never races the edge
   task fall;
      begin
         scl = 1'b0;
         repeat (2) @(posedge clock);
         #1;
      end
   endtask
   task start;
      begin
         sda_rel = 1'b1;
         half;
         scl = 1'b1;
         half;
         sda_rel = 1'b0;
         half;
         fall;
      end
   endtask
   task stop;
      begin
         sda_rel = 1'b0;
         half;
         scl = 1'b1;
         half;
         sda_rel = 1'b1;
         half;
      end
   endtask
   task put_bit(input b);
      begin
         sda_rel = b;
         half;
         scl = 1'b1;
         half;
         fall;
      end
   endtask
   // sampled five clocks into the fifteen-clock high phase
   task get_bit(output b);
      begin
         sda_rel = 1'b1;
         half;
         scl = 1'b1;
         repeat (5) @(posedge clock);
         b = sda_line;
         half;
         fall;
      end
   endtask
   // address or data byte, msb first, then the device's ack
   task send(input [7:0] d, output ack);
      integer i;
      reg b;
      begin
         for (i = 7; i >= 0; i = i - 1)
            put_bit(d[i]);
         get_bit(b);
         ack = ~b;
      end
   endtask
   task fetch(output [7:0] d, input last);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            get_bit(d[i]);
         put_bit(last);
      end
   endtask
endmodule

// File: tb/test_mmsc_top.sv
// testbench of the management slave controller
`timescale 1ns/1ns
module test_mmsc_top;
   reg clock = 1'b0;
   reg nrst = 1'b0;
   reg module_select_n = 1'b0;
   reg module_reset_n = 1'b1;
   reg low_power_select = 1'b0;
   reg fault_event = 1'b0;
   wire scl, sda_rel, sda_out_q, sda_oe_n_q, presence_n_q;
   wire attention_out_q, attention_oe_n_q, low_power_active_q;
   wire data_not_ready_q;
   // pull-up wire: low when either party pulls it
   wire sda_line = sda_rel & sda_oe_n_q;
   integer errors = 0;
   integer comparisons = 0;
   integer i;
   reg [7:0] d;
   reg [7:0] pg;
   reg ack;
   mmsc_top #(.INIT_CYCLES(32'd600), .RESET_MIN_CYCLES(16'd20)) i_mmsc_top (
      .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
      .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q),
      .module_select_n(module_select_n), .module_reset_n(module_reset_n),
      .low_power_select(low_power_select), .fault_event(fault_event),
      .presence_n_q(presence_n_q), .attention_out_q(attention_out_q),
      .attention_oe_n_q(attention_oe_n_q),
      .low_power_active_q(low_power_active_q),
      .data_not_ready_q(data_not_ready_q));
   mmsc_host i_mmsc_host (.clock(clock), .sda_line(sda_line), .scl(scl),
      .sda_rel(sda_rel));
   initial begin
      forever #5 clock = ~clock;
   end
   task complete_run;
      begin
         $display("errors %0d comparisons %0d", errors, comparisons);
         if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task check(input [7:0] seen, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED %0t saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clock);
         #1;
      end
   endtask
   // pointer then one data byte
   task wr(input [7:0] a, input [7:0] v);
      begin
         i_mmsc_host.start;
         i_mmsc_host.send(8'ha0, ack);
         check({7'h0, ack}, 8'h01);
         i_mmsc_host.send(a, ack);
         i_mmsc_host.send(v, ack);
         i_mmsc_host.stop;
      end
   endtask
   // random read through a repeated start
   task rd(input [7:0] a, output [7:0] v);
      begin
         i_mmsc_host.start;
         i_mmsc_host.send(8'ha0, ack);
         i_mmsc_host.send(a, ack);
         i_mmsc_host.start;
         i_mmsc_host.send(8'ha1, ack);
         i_mmsc_host.fetch(v, 1'b1);
         i_mmsc_host.stop;
      end
   endtask
   // status is disregarded until the completion attention shows
   task wait_ready;
      integer n;
      begin
         n = 0;
         while (n < 2000 && !(data_not_ready_q === 1'b0 &&
                attention_oe_n_q === 1'b0)) begin
            tick(1);
            n = n + 1;
         end
         check({7'h0, data_not_ready_q}, 8'h00);
         check({7'h0, attention_oe_n_q}, 8'h00);
      end
   endtask
   initial begin
      tick(60000);
      errors = errors + 1;
      complete_run;
   end
   initial begin
      tick(8);
      nrst = 1'b1;
      check({7'h0, presence_n_q}, 8'h00);
      check({7'h0, data_not_ready_q}, 8'h01);
      wait_ready;
      rd(8'h03, d);
      check(d, 8'h01);
      tick(10);
      check({7'h0, attention_oe_n_q}, 8'h01);
      rd(8'h02, d);
      check(d, 8'h00);
      // pages 00, 02, 03 and an invalid one share the upper range
      for (i = 0; i < 4; i = i + 1) begin
         pg = (i == 0) ? 8'h00 : (i == 1) ? 8'h02 : (i == 2) ? 8'h03 : 8'h05;
         wr(8'h7f, pg);
         rd(8'h7f, d);
         check(d, pg);
         wr(8'hf0, 8'h5a);
         rd(8'hf0, d);
         check(d, (i == 1 || i == 2) ? 8'h5a : 8'h00);
      end
      wr(8'h7f, 8'h02);
      wr(8'h56, 8'h33);
      rd(8'h56, d);
      check(d, 8'h33);
      wr(8'h10, 8'h77);
      rd(8'h10, d);
      check(d, 8'h00);
      i_mmsc_host.start;
      i_mmsc_host.send(8'ha2, ack);
      i_mmsc_host.stop;
      check({7'h0, ack}, 8'h00);
      module_select_n = 1'b1;
      tick(8);
      i_mmsc_host.start;
      i_mmsc_host.send(8'ha0, ack);
      i_mmsc_host.stop;
      check({7'h0, ack}, 8'h00);
      module_select_n = 1'b0;
      tick(8);
      fault_event = 1'b1;
      tick(1);
      fault_event = 1'b0;
      tick(4);
      check({7'h0, attention_oe_n_q}, 8'h00);
      rd(8'h03, d);
      check(d, 8'h02);
      low_power_select = 1'b1;
      tick(10);
      check({7'h0, low_power_active_q}, 8'h01);
      low_power_select = 1'b0;
      tick(10);
      check({7'h0, low_power_active_q}, 8'h00);
      // a short pulse must leave the page choice alone
      module_reset_n = 1'b0;
      tick(10);
      module_reset_n = 1'b1;
      tick(10);
      check({7'h0, data_not_ready_q}, 8'h00);
      rd(8'h7f, d);
      check(d, 8'h02);
      module_reset_n = 1'b0;
      tick(60);
      check({7'h0, data_not_ready_q}, 8'h01);
      module_reset_n = 1'b1;
      tick(400);
      check({7'h0, data_not_ready_q}, 8'h01);
      wait_ready;
      rd(8'h7f, d);
      check(d, 8'h00);
      rd(8'h56, d);
      check(d, 8'h00);
      wr(8'h7f, 8'h02);
      rd(8'hf0, d);
      check(d, 8'h5a);
      complete_run;
   end
endmodule
